// File: design/isz_increment_core.sv
// How it works
// (RULE1) Read file register, add one, deliver sum
// (RULE2) Destination bit zero writes working register only
// (RULE3) Destination bit one writes back same register
// (RULE4) Seven bit address, one destination select bit
// (RULE5) Opcode 001010 is plain increment, updates zero
// (RULE6) Opcode 001111 is increment-skip, status untouched
// (RULE7) Zero result squashes next instruction into nop
// (RULE8) Skip costs one extra all-nop cycle
// (RULE9) Decode, read, compute, write in phases one-four
// (RULE10) Modulo 256 sum; zero flag means result zero
// (RULE11) Plain increment: one word, one cycle
module isz_increment_core #(
  parameter int DATA_W = 8
) (
  // Clock and reset
  input  wire logic                  ref_clk,
  input  wire logic                  rstn,
  // Instruction fetch
  input  wire isz_pkg::isz_instr_s   instr_word,
  input  wire logic                  instr_valid,
  output logic                       instr_ready,
  // Data memory, read data returns one clock after the read strobe
  output isz_pkg::isz_file_req_s     file_req,
  input  wire logic [DATA_W-1:0]     file_rd_data,
  // Core state
  output logic [DATA_W-1:0]          w_value,
  output logic                       z_flag,
  output isz_pkg::isz_phase_e        phase,
  output logic                       nop_cycle
);

  // Structs are laid out from the package widths, so the parameter must match
  if (DATA_W != isz_pkg::DATA_W) begin : g_width_check
    $error("isz_increment_core: DATA_W must equal the package data width");
  end

  isz_pkg::isz_kind_e       kind;
  logic [DATA_W-1:0]        result;
  logic                     dest;
  isz_pkg::isz_phase_e      next_phase;
  isz_pkg::isz_kind_e       next_kind;
  logic [DATA_W-1:0]        next_result;
  logic                     next_dest;
  isz_pkg::isz_file_req_s   next_file_req;
  logic [DATA_W-1:0]        next_w_value;
  logic                     next_z_flag;
  logic                     next_nop_cycle;

  // Opcode decode, shared by the datapath and the checks
  function automatic isz_pkg::isz_kind_e decode(input isz_pkg::isz_instr_s ins);
    case (ins.opcode)
      isz_pkg::OPC_INCREMENT_FILE: decode = isz_pkg::K_INC;      // RULE5
      isz_pkg::OPC_INCREMENT_SKIP: decode = isz_pkg::K_INC_SKIP; // RULE6
      default:                     decode = isz_pkg::K_NONE;
    endcase
  endfunction

  // Wraps at 256, so all ones becomes zero
  function automatic logic [DATA_W-1:0] inc8(input logic [DATA_W-1:0] v);
    inc8 = DATA_W'(v + isz_pkg::INC_STEP); // RULE10
  endfunction

  // Instruction is taken only in phase one
  assign instr_ready = (phase == isz_pkg::PH_ONE);

  // Phase sequencer and per-cycle datapath
  always_comb begin
    next_phase     = phase;
    next_kind      = kind;
    next_result    = result;
    next_dest      = dest;
    next_file_req  = file_req;
    next_w_value   = w_value;
    next_z_flag    = z_flag;
    next_nop_cycle = nop_cycle;
    next_file_req.rd_en = 1'b0;
    next_file_req.wr_en = 1'b0;
    case (phase)
      isz_pkg::PH_ONE: begin
        next_phase = isz_pkg::PH_TWO; // RULE9
        // A squashed cycle ignores the fetched word entirely
        if (instr_valid && !nop_cycle) begin
          next_kind = decode(instr_word); // RULE7
        end else begin
          next_kind = isz_pkg::K_NONE; // RULE8
        end
        next_dest = instr_word.dest; // RULE4
        if (instr_valid && !nop_cycle && decode(instr_word) != isz_pkg::K_NONE) begin
          next_file_req.rd_en = 1'b1; // RULE9
          next_file_req.addr  = instr_word.addr; // RULE4
        end
      end
      isz_pkg::PH_TWO: begin
        next_phase = isz_pkg::PH_THREE;
      end
      isz_pkg::PH_THREE: begin
        next_phase  = isz_pkg::PH_FOUR;
        next_result = inc8(file_rd_data); // RULE1
        // Write-back strobe stands during phase four
        if (kind != isz_pkg::K_NONE && dest == isz_pkg::DEST_FILE) begin
          next_file_req.wr_en = 1'b1; // RULE3
          next_file_req.wdata = inc8(file_rd_data);
        end
      end
      isz_pkg::PH_FOUR: begin
        next_phase = isz_pkg::PH_ONE; // RULE11
        if (kind != isz_pkg::K_NONE && dest == isz_pkg::DEST_WORKING) begin
          next_w_value = result; // RULE2
        end
        if (kind == isz_pkg::K_INC) begin
          next_z_flag = (result == isz_pkg::ZERO_RESULT); // RULE10
        end
        // Squash lasts exactly the following instruction cycle
        next_nop_cycle = (kind == isz_pkg::K_INC_SKIP) &&
                         (result == isz_pkg::ZERO_RESULT); // RULE7
      end
      default: begin
        next_phase = isz_pkg::PH_ONE;
      end
    endcase
  end

  // State registers
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      phase          <= isz_pkg::PH_ONE;
      kind           <= isz_pkg::K_NONE;
      result         <= isz_pkg::ZERO_RESULT;
      dest           <= isz_pkg::DEST_WORKING;
      file_req.rd_en <= 1'b0;
      file_req.wr_en <= 1'b0;
      file_req.addr  <= isz_pkg::ADDR_RESET;
      file_req.wdata <= isz_pkg::ZERO_RESULT;
      w_value        <= isz_pkg::WORKING_RESET;
      z_flag         <= isz_pkg::ZERO_RESET;
      nop_cycle      <= 1'b0;
    end else begin
      phase          <= next_phase;
      kind           <= next_kind;
      result         <= next_result;
      dest           <= next_dest;
      file_req       <= next_file_req;
      w_value        <= next_w_value;
      z_flag         <= next_z_flag;
      nop_cycle      <= next_nop_cycle;
    end
  end

  // Checks run on the core clock and sleep through reset
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  // Phase four closes on an active increment
  logic end_active;
  assign end_active = (phase == isz_pkg::PH_FOUR) && (kind != isz_pkg::K_NONE);

  inc_sum_a: assert property ( // RULE1
    end_active |-> result == inc8($past(file_rd_data)))
    else $error("increment result is not read data plus one");

  dest_working_a: assert property ( // RULE2
    end_active && dest == isz_pkg::DEST_WORKING |->
      !file_req.wr_en ##1 w_value == $past(result))
    else $error("working destination not honoured");

  dest_file_a: assert property ( // RULE3
    end_active && dest == isz_pkg::DEST_FILE |->
      file_req.wr_en && file_req.wdata == result ##1 $stable(w_value))
    else $error("file destination not honoured");

  addr_taken_a: assert property ( // RULE4
    phase == isz_pkg::PH_ONE && instr_valid && !nop_cycle &&
      decode(instr_word) != isz_pkg::K_NONE |=>
      file_req.rd_en && file_req.addr == $past(instr_word.addr) &&
      dest == $past(instr_word.dest) ##2 file_req.addr == $past(file_req.addr, 2))
    else $error("file address or destination not captured");

  zero_update_a: assert property ( // RULE5
    phase == isz_pkg::PH_FOUR && kind == isz_pkg::K_INC |=>
      z_flag == ($past(result) == isz_pkg::ZERO_RESULT))
    else $error("zero flag wrong after plain increment");

  status_kept_a: assert property ( // RULE6
    phase == isz_pkg::PH_FOUR && kind != isz_pkg::K_INC |=> $stable(z_flag))
    else $error("status changed by a non plain increment cycle");

  skip_taken_a: assert property ( // RULE7
    end_active && kind == isz_pkg::K_INC_SKIP && result == isz_pkg::ZERO_RESULT |=>
      nop_cycle[*4] ##1 !nop_cycle)
    else $error("skip cycle not exactly one instruction cycle");

  no_skip_a: assert property ( // RULE7
    end_active && result != isz_pkg::ZERO_RESULT |=> !nop_cycle)
    else $error("nonzero result squashed the next instruction");

  nop_quiet_a: assert property ( // RULE8
    nop_cycle && phase == isz_pkg::PH_ONE |=>
      kind == isz_pkg::K_NONE && !file_req.rd_en ##2 !file_req.wr_en ##1 $stable(w_value))
    else $error("squashed cycle performed an operation");

  phase_order_a: assert property ( // RULE9
    (file_req.rd_en |-> phase == isz_pkg::PH_TWO) and
    (file_req.wr_en |-> phase == isz_pkg::PH_FOUR))
    else $error("memory access outside its phase");

  single_cycle_a: assert property ( // RULE11
    phase == isz_pkg::PH_FOUR && kind == isz_pkg::K_INC |=>
      !nop_cycle && phase == isz_pkg::PH_ONE)
    else $error("plain increment altered program flow");

  cov_inc_w_c:   cover property (end_active && kind == isz_pkg::K_INC && !dest);
  cov_skip_c:    cover property (end_active && kind == isz_pkg::K_INC_SKIP &&
                                 result == isz_pkg::ZERO_RESULT);
  cov_noskip_c:  cover property (end_active && kind == isz_pkg::K_INC_SKIP &&
                                 result != isz_pkg::ZERO_RESULT && dest);
  // Wrap to zero written back, and the last phase of a squashed cycle
  cov_zero_file_c: cover property (end_active && kind == isz_pkg::K_INC && dest &&
                                   result == isz_pkg::ZERO_RESULT);
  cov_squash_c:  cover property (nop_cycle && phase == isz_pkg::PH_FOUR);

endmodule

// File: design/isz_pkg.sv
package isz_pkg;

  // Data path and instruction field widths
  localparam int DATA_W  = 8;
  localparam int ADDR_W  = 7;
  localparam int OPC_W   = 6;
  localparam int INSTR_W = 14;

  // Opcode patterns in the top six bits of the instruction word
  localparam logic [OPC_W-1:0] OPC_INCREMENT_FILE = 6'h0A;
  localparam logic [OPC_W-1:0] OPC_INCREMENT_SKIP = 6'h0F;

  // Destination select values
  localparam logic DEST_WORKING = 1'h0;
  localparam logic DEST_FILE    = 1'h1;

  // Increment step and result that triggers the skip
  localparam logic [DATA_W-1:0] INC_STEP    = 8'h01;
  localparam logic [DATA_W-1:0] ZERO_RESULT = 8'h00;

  // Values after reset
  localparam logic [DATA_W-1:0] WORKING_RESET = 8'h00;
  localparam logic              ZERO_RESET    = 1'h0;
  localparam logic [ADDR_W-1:0] ADDR_RESET    = 7'h00;

  // Phases of one instruction cycle, one core clock each
  localparam int PHASES_PER_CYCLE = 4;

  typedef enum logic [1:0] {
    PH_ONE,
    PH_TWO,
    PH_THREE,
    PH_FOUR
  } isz_phase_e;

  typedef enum logic [1:0] {
    K_NONE,
    K_INC,
    K_INC_SKIP
  } isz_kind_e;

  // Instruction word split into its fields
  typedef struct packed {
    logic [OPC_W-1:0]  opcode;
    logic              dest;
    logic [ADDR_W-1:0] addr;
  } isz_instr_s;

  // Request to the data memory
  typedef struct packed {
    logic              rd_en;
    logic              wr_en;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } isz_file_req_s;

endpackage

// File: test/tb_increment_skip_zero_ops.sv
module tb_increment_skip_zero_ops;
  timeunit 1ns;
  timeprecision 1ps;

  logic                   ref_clk = 1'b0;
  logic                   rstn = 1'b0;
  isz_pkg::isz_instr_s    instr_word = '0;
  logic                   instr_valid = 1'b0;
  logic                   instr_ready;
  isz_pkg::isz_file_req_s file_req;
  logic [7:0]             file_rd_data = 8'h00;
  logic [7:0]             w_value;
  logic                   z_flag;
  isz_pkg::isz_phase_e    phase;
  logic                   nop_cycle;
  int                     errors = 0;
  int                     checked = 0;
  logic [7:0]             exp_w = 8'h00;
  logic                   exp_z = 1'b0;

  // 100 MHz core clock, one phase per clock
  always #5 ref_clk = ~ref_clk;

  isz_increment_core #(.DATA_W(8)) dut_u (
    .ref_clk      (ref_clk),
    .rstn         (rstn),
    .instr_word   (instr_word),
    .instr_valid  (instr_valid),
    .instr_ready  (instr_ready),
    .file_req     (file_req),
    .file_rd_data (file_rd_data),
    .w_value      (w_value),
    .z_flag       (z_flag),
    .phase        (phase),
    .nop_cycle    (nop_cycle)
  );

  // Byte compare, case equality so unknowns fail
  task automatic chk(input string name, input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask

  // Flag and strobe compare, case equality so unknowns fail
  task automatic chk_bit(input string name, input logic got, input logic exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %s expected %b seen %b", name, exp, got);
    end
  endtask

  task automatic report_and_stop;
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // One instruction; bench model of working register and zero flag
  task automatic exec(input logic [5:0] opc, input logic d, input logic [6:0] a,
                      input logic [7:0] data);
    logic [7:0] sum;
    logic       inc;
    logic       skip;
    int         n;
    sum  = data + 8'h01;
    inc  = (opc == isz_pkg::OPC_INCREMENT_FILE) || (opc == isz_pkg::OPC_INCREMENT_SKIP);
    skip = (opc == isz_pkg::OPC_INCREMENT_SKIP) && (sum == 8'h00);
    n = 0;
    while (phase !== isz_pkg::PH_FOUR && n < 8) begin
      @(negedge ref_clk);
      n++;
    end
    chk_bit("phase_four", phase == isz_pkg::PH_FOUR, 1'b1);
    @(posedge ref_clk);
    instr_word <= {opc, d, a};
    instr_valid <= 1'b1;
    @(negedge ref_clk);
    chk_bit("instr_ready", instr_ready, 1'b1);
    chk_bit("nop_idle", nop_cycle, 1'b0);
    @(posedge ref_clk);
    // A word that changes W, offered only in a slot that must be squashed
    instr_word <= {isz_pkg::OPC_INCREMENT_FILE, isz_pkg::DEST_WORKING, a};
    instr_valid <= skip;
    @(negedge ref_clk);
    chk_bit("busy", instr_ready, 1'b0);
    chk_bit("rd_en", file_req.rd_en, inc);
    if (inc) chk("rd_addr", {1'b0, file_req.addr}, {1'b0, a});
    @(posedge ref_clk);
    file_rd_data <= data;
    @(posedge ref_clk);
    file_rd_data <= ~data; // Stale data must not be used
    @(negedge ref_clk);
    chk_bit("wr_en", file_req.wr_en, inc & d);
    if (inc && d) chk("wdata", file_req.wdata, sum);
    if (inc && d) chk("wr_addr", {1'b0, file_req.addr}, {1'b0, a});
    if (inc && !d) exp_w = sum;
    if (opc == isz_pkg::OPC_INCREMENT_FILE) exp_z = (sum == 8'h00);
    @(negedge ref_clk);
    chk("w_value", w_value, exp_w);
    chk_bit("z_flag", z_flag, exp_z);
    chk_bit("nop_cycle", nop_cycle, skip);
    if (skip) begin
      @(negedge ref_clk);
      chk_bit("squash_rd", file_req.rd_en, 1'b0);
      @(posedge ref_clk);
      instr_valid <= 1'b0;
      repeat (2) @(negedge ref_clk);
      chk_bit("nop_hold", nop_cycle, 1'b1);
      // W and Z would move at the edge ending phase four, so look after it
      @(negedge ref_clk);
      chk("squash_w", w_value, exp_w);
      chk_bit("squash_z", z_flag, exp_z);
      chk_bit("nop_end", nop_cycle, 1'b0);
    end
  endtask

  // Outputs while reset is held
  task automatic reset_checks;
    chk_bit("rst_phase", phase == isz_pkg::PH_ONE, 1'b1);
    chk_bit("rst_rd", file_req.rd_en, 1'b0);
    chk_bit("rst_wr", file_req.wr_en, 1'b0);
    chk("rst_w", w_value, isz_pkg::WORKING_RESET);
    chk_bit("rst_z", z_flag, isz_pkg::ZERO_RESET);
    chk_bit("rst_nop", nop_cycle, 1'b0);
  endtask

  task automatic test_reset;
    reset_checks;
    $display("test reset done");
  endtask

  // Reset in phase three of an idle cycle clears W and Z; the core restarts in phase one
  task automatic test_mid_reset;
    exec(isz_pkg::OPC_INCREMENT_SKIP, isz_pkg::DEST_WORKING, 7'h22, 8'h33);
    repeat (2) @(posedge ref_clk);
    rstn <= 1'b0;
    @(negedge ref_clk);
    reset_checks;
    repeat (2) @(posedge ref_clk);
    rstn <= 1'b1;
    exp_w = isz_pkg::WORKING_RESET;
    exp_z = isz_pkg::ZERO_RESET;
    $display("test mid reset done");
  endtask

  // Plain increment: both destinations, wrap to zero sets the flag
  task automatic test_plain;
    exec(isz_pkg::OPC_INCREMENT_FILE, isz_pkg::DEST_WORKING, 7'h05, 8'h41);
    exec(isz_pkg::OPC_INCREMENT_FILE, isz_pkg::DEST_WORKING, 7'h00, 8'h7F);
    exec(isz_pkg::OPC_INCREMENT_FILE, isz_pkg::DEST_FILE, 7'h7F, 8'hFF);
    $display("test plain done");
  endtask

  // Flag left set by the previous test must survive skip to W, skip to file and no-skip to W
  task automatic test_skip;
    exec(isz_pkg::OPC_INCREMENT_SKIP, isz_pkg::DEST_WORKING, 7'h10, 8'h10);
    exec(isz_pkg::OPC_INCREMENT_SKIP, isz_pkg::DEST_FILE, 7'h7F, 8'hFF);
    exec(isz_pkg::OPC_INCREMENT_SKIP, isz_pkg::DEST_WORKING, 7'h01, 8'hFF);
    $display("test skip done");
  endtask

  // Other opcode gives a cycle with no access
  task automatic test_other;
    exec(6'h07, isz_pkg::DEST_FILE, 7'h22, 8'h33);
    $display("test other done");
  endtask

  initial begin
    repeat (16) @(posedge ref_clk);
    test_reset;
    rstn <= 1'b1;
    test_plain;
    test_skip;
    test_mid_reset;
    test_other;
    report_and_stop;
  end

  // About 92 clocks of tests; generous bound
  initial begin
    #20000;
    errors++;
    report_and_stop;
  end
endmodule
